/* core/bpot_regs.sv */
/*
 * bpot_regs: configuration registers for the port options, retry limit,
 * delayed-read discard timers and capability headers of a two-port bridge,
 * plus the two discard countdowns themselves.
 * assumes: axi4-lite master on the same clock; the bridge datapath pulses
 * the completion-delivered strobes and consumes the discard pulses.
 */
// The AXI4-Lite slave port was left to the implementer.
// Function
// - bit 8 at 0 sends write-invalidate as plain write, at 1 cuts it at line ends; reset 0.
// - bit 9 at 0 keeps normal locking, at 1 long requests for locked cycles; reset 0.
// - bit 10 at 0 drops sec request after frame, at 1 holds to empty fifo or stop; reset 1.
// - option bit 11 applies the same request hold policy to the primary master; resets to 1.
// - the 32-bit r/w retry limit bounds attempts before a retry timeout; reset 0100_0000h.
// - sec discard value: bits 15:0 or 3Ch bit 25 select, last written wins; reset 8000h.
// - pri discard value: bits 31:16 or 3Ch bit 24 select, last written wins; reset 8000h.
// - each discard timer starts once the completion data it guards is in the bridge.
// - on expiry of a discard timer the buffered data of its delayed transaction is discarded.
// - the slot capability header reads id 04h in bits 7:0, read-only.
// - the slot capability next pointer reads e4h with hot swap enabled and 00h otherwise.
// - slot number, first-in-chassis and chassis number are r/w, reset 0; bits 23:22 read 0.
// - the power capability header reads id 01h in bits 7:0, read-only.
// - the power capability next pointer reads b0h.
`timescale 1ns/1ns
module bpot_regs (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        hot_swap_enable_input,
    input  wire logic        sec_cpl_delivered,
    input  wire logic        pri_cpl_delivered,
    input  wire logic        sec_cpl_retired,
    input  wire logic        pri_cpl_retired,
    output logic             sec_mwi_disconnect,
    output logic             long_lock_request,
    output logic             sec_req_hold,
    output logic             pri_req_hold,
    output logic [31:0]      retry_limit,
    output logic             sec_discard,
    output logic             pri_discard,
    output logic             irq
);
    typedef struct packed {
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [3:0]  port_opt;
        logic [31:0] retry;
        logic [15:0] sec_init;
        logic [15:0] pri_init;
        logic [1:0]  tmr_sel;
        logic [4:0]  slot_num;
        logic        first_chassis;
        logic [7:0]  chassis;
        logic        sec_run;
        logic        pri_run;
        logic [15:0] sec_cnt;
        logic [15:0] pri_cnt;
        logic        sec_disc;
        logic        pri_disc;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic        irq;
        logic        hs_m;
        logic        hs_s1;
        logic        hs_s2;
        logic        hs_ok;
        logic        aw_rdy;
        logic        w_rdy;
        logic        ar_rdy;
    } bpot_state_t;

    bpot_state_t st_r;
    bpot_state_t st_nxt;

    logic        hs_sync;
    logic        hs_meta;
    logic [31:0] wmask;
    logic [31:0] wd;
    logic [31:0] slot_word;
    logic        sec_exp;
    logic        pri_exp;
    logic        wr_fire;

    // hot swap strap is a pin: first stage feeds only the second
    assign hs_meta = st_r.hs_m;
    assign hs_sync = st_r.hs_s1;

    assign wmask = {{8{st_r.w_strb[3]}}, {8{st_r.w_strb[2]}},
                    {8{st_r.w_strb[1]}}, {8{st_r.w_strb[0]}}};
    assign wd    = st_r.w_data & wmask;

    assign slot_word = {st_r.chassis, 2'b00, st_r.first_chassis, st_r.slot_num,
                        (st_r.hs_ok ? bpot_pkg::SLOT_NEXT_HS
                                    : bpot_pkg::SLOT_NEXT_NONE),
                        bpot_pkg::SLOT_CAP_ID};

    assign sec_exp = st_r.sec_run && (st_r.sec_cnt == 16'h0000);
    assign pri_exp = st_r.pri_run && (st_r.pri_cnt == 16'h0000);
    assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  en);
        logic [15:0] r;
        r = old_v;
        if (en[0]) begin
            r[7:0] = new_v[7:0];
        end
        if (en[1]) begin
            r[15:8] = new_v[15:8];
        end
        return r;
    endfunction : merge16

    always_comb begin
        logic do_wr;
        logic [31:0] rd;
        logic        hit;
        do_wr  = 1'b0;
        rd     = 32'h0000_0000;
        hit    = 1'b1;
        st_nxt = st_r;

        st_nxt.hs_m  = hot_swap_enable_input;
        st_nxt.hs_s1 = hs_meta;
        st_nxt.hs_s2 = hs_sync;
        // a level change counts only once the last two stages agree
        if (hs_sync == st_r.hs_s2) begin
            st_nxt.hs_ok = hs_sync;
        end
        st_nxt.sec_disc = 1'b0;
        st_nxt.pri_disc = 1'b0;

        // write channel: address and data taken in either order
        if (s_axi_awvalid && !st_r.aw_got && !st_r.bvalid) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_got && !st_r.bvalid) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            do_wr         = 1'b1;
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = bpot_pkg::RESP_OKAY;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // discard countdowns; a fresh delivery restarts from the start value
        if (st_r.sec_run) begin
            st_nxt.sec_cnt = st_r.sec_cnt - 16'h0001;
        end
        if (sec_exp || sec_cpl_retired) begin
            st_nxt.sec_run  = 1'b0;
            st_nxt.sec_disc = sec_exp;
        end
        if (sec_cpl_delivered) begin
            st_nxt.sec_run = 1'b1;
            st_nxt.sec_cnt = st_r.sec_init;
        end
        if (st_r.pri_run) begin
            st_nxt.pri_cnt = st_r.pri_cnt - 16'h0001;
        end
        if (pri_exp || pri_cpl_retired) begin
            st_nxt.pri_run  = 1'b0;
            st_nxt.pri_disc = pri_exp;
        end
        if (pri_cpl_delivered) begin
            st_nxt.pri_run = 1'b1;
            st_nxt.pri_cnt = st_r.pri_init;
        end

        // sticky events: set wins over a write-one clear in the same cycle
        if (do_wr && st_r.aw_addr == bpot_pkg::OFS_IRQ_STATUS) begin
            st_nxt.irq_stat = st_r.irq_stat & ~wd[1:0];
        end
        if (do_wr) begin
            unique case (st_r.aw_addr)
                bpot_pkg::OFS_PORT_OPT: begin
                    if (st_r.w_strb[1]) begin
                        st_nxt.port_opt = st_r.w_data[bpot_pkg::BIT_PRI_HOLD:
                                                      bpot_pkg::BIT_SEC_MWI];
                    end
                end
                bpot_pkg::OFS_RETRY: begin
                    st_nxt.retry = (st_r.retry & ~wmask) | wd;
                end
                bpot_pkg::OFS_DISCARD: begin
                    st_nxt.sec_init = merge16(st_r.sec_init, st_r.w_data[15:0],
                                              st_r.w_strb[1:0]);
                    st_nxt.pri_init = merge16(st_r.pri_init, st_r.w_data[31:16],
                                              st_r.w_strb[3:2]);
                end
                bpot_pkg::OFS_TMR_SEL: begin
                    // the select overwrites the fine value: last write wins
                    if (st_r.w_strb[3]) begin
                        st_nxt.tmr_sel  = st_r.w_data[bpot_pkg::BIT_SEL_SEC:
                                                      bpot_pkg::BIT_SEL_PRI];
                        st_nxt.sec_init = st_r.w_data[bpot_pkg::BIT_SEL_SEC]
                                        ? bpot_pkg::DISCARD_LONG
                                        : bpot_pkg::DISCARD_SHORT;
                        st_nxt.pri_init = st_r.w_data[bpot_pkg::BIT_SEL_PRI]
                                        ? bpot_pkg::DISCARD_LONG
                                        : bpot_pkg::DISCARD_SHORT;
                    end
                end
                bpot_pkg::OFS_SLOT_CAP: begin
                    // id and next pointer are constants, writes fall away
                    if (st_r.w_strb[2]) begin
                        st_nxt.slot_num      = st_r.w_data[20:16];
                        st_nxt.first_chassis = st_r.w_data[21];
                    end
                    if (st_r.w_strb[3]) begin
                        st_nxt.chassis = st_r.w_data[31:24];
                    end
                end
                bpot_pkg::OFS_IRQ_MASK: begin
                    if (st_r.w_strb[0]) begin
                        st_nxt.irq_mask = st_r.w_data[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        if (sec_exp) begin
            st_nxt.irq_stat[0] = 1'b1;
        end
        if (pri_exp) begin
            st_nxt.irq_stat[1] = 1'b1;
        end
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);

        // read channel
        unique case (s_axi_araddr)
            bpot_pkg::OFS_PORT_OPT:   rd = {20'h00000, st_r.port_opt, 8'h00};
            bpot_pkg::OFS_RETRY:      rd = st_r.retry;
            bpot_pkg::OFS_DISCARD:    rd = {st_r.pri_init, st_r.sec_init};
            bpot_pkg::OFS_TMR_SEL:    rd = {6'h00, st_r.tmr_sel, 24'h000000};
            bpot_pkg::OFS_SLOT_CAP:   rd = slot_word;
            bpot_pkg::OFS_POWER_CAP:  rd = {16'h0000, bpot_pkg::POWER_NEXT,
                                            bpot_pkg::POWER_CAP_ID};
            bpot_pkg::OFS_IRQ_STATUS: rd = {30'h0, st_r.irq_stat};
            bpot_pkg::OFS_IRQ_MASK:   rd = {30'h0, st_r.irq_mask};
            bpot_pkg::OFS_TMR_STATUS: rd = {14'h0, st_r.pri_run, st_r.sec_run,
                                            16'h0000};
            default:                  hit = 1'b0;
        endcase
        if (s_axi_arvalid && !st_r.rvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd;
            st_nxt.rresp  = hit ? bpot_pkg::RESP_OKAY : bpot_pkg::RESP_SLVERR;
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end

        if (rst) begin
            st_nxt               = '0;
            st_nxt.port_opt      = bpot_pkg::PORT_OPT_RST;
            st_nxt.retry         = bpot_pkg::RETRY_RST;
            st_nxt.sec_init      = bpot_pkg::DISCARD_RST;
            st_nxt.pri_init      = bpot_pkg::DISCARD_RST;
            st_nxt.tmr_sel       = 2'b11;
        end
        // readies leave flops; they mirror the next busy state
        st_nxt.aw_rdy = !st_nxt.bvalid && !st_nxt.aw_got;
        st_nxt.w_rdy  = !st_nxt.bvalid && !st_nxt.w_got;
        st_nxt.ar_rdy = !st_nxt.rvalid;
    end

    always_ff @(posedge clock) begin
        st_r <= st_nxt;
    end

    assign s_axi_awready      = st_r.aw_rdy;
    assign s_axi_wready       = st_r.w_rdy;
    assign s_axi_bvalid       = st_r.bvalid;
    assign s_axi_bresp        = st_r.bresp;
    assign s_axi_arready      = st_r.ar_rdy;
    assign s_axi_rvalid       = st_r.rvalid;
    assign s_axi_rdata        = st_r.rdata;
    assign s_axi_rresp        = st_r.rresp;
    assign sec_mwi_disconnect = st_r.port_opt[0];
    assign long_lock_request  = st_r.port_opt[1];
    assign sec_req_hold       = st_r.port_opt[2];
    assign pri_req_hold       = st_r.port_opt[3];
    assign retry_limit        = st_r.retry;
    assign sec_discard        = st_r.sec_disc;
    assign pri_discard        = st_r.pri_disc;
    assign irq                = st_r.irq;

    // assertions
    opt_reset_a: assert property (@(posedge clock)
        (!rst && $past(rst)) |->
        (sec_req_hold && pri_req_hold && !sec_mwi_disconnect && !long_lock_request))
        else $error("option bits wrong after reset");
    retry_reset_a: assert property (@(posedge clock)
        (!rst && $past(rst)) |-> retry_limit == 32'h0100_0000)
        else $error("retry limit reset value wrong");
    sec_start_a: assert property (@(posedge clock) disable iff (rst)
        sec_cpl_delivered |=> (st_r.sec_run && st_r.sec_cnt == $past(st_r.sec_init)))
        else $error("secondary timer did not load");
    pri_start_a: assert property (@(posedge clock) disable iff (rst)
        pri_cpl_delivered |=> (st_r.pri_run && st_r.pri_cnt == $past(st_r.pri_init)))
        else $error("primary timer did not load");
    sec_expire_a: assert property (@(posedge clock) disable iff (rst)
        (sec_exp && !sec_cpl_delivered) |=> sec_discard ##1 !sec_discard)
        else $error("secondary discard pulse wrong");
    pri_expire_a: assert property (@(posedge clock) disable iff (rst)
        (pri_exp && !pri_cpl_delivered) |=> pri_discard ##1 !pri_discard)
        else $error("primary discard pulse wrong");
    slot_id_a: assert property (@(posedge clock) disable iff (rst)
        slot_word[7:0] == 8'h04 && slot_word[23:22] == 2'b00)
        else $error("slot slot_cap_header_id wrong");
    slot_next_a: assert property (@(posedge clock) disable iff (rst)
        (st_r.hs_s1 == st_r.hs_s2) |=> st_r.hs_ok == $past(st_r.hs_s2))
        else $error("hot swap level not taken");
    power_rd_a: assert property (@(posedge clock) disable iff (rst)
        (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == 8'hdc) |=>
        (s_axi_rvalid && s_axi_rdata[15:0] == 16'hb001))
        else $error("power capability header wrong");
    opt_write_a: assert property (@(posedge clock) disable iff (rst)
        (wr_fire && st_r.aw_addr == bpot_pkg::OFS_PORT_OPT && st_r.w_strb[1]) |=>
        ({pri_req_hold, sec_req_hold, long_lock_request, sec_mwi_disconnect}
            == $past(st_r.w_data[11:8])))
        else $error("option bits not written");
    retry_write_a: assert property (@(posedge clock) disable iff (rst)
        (wr_fire && st_r.aw_addr == bpot_pkg::OFS_RETRY && st_r.w_strb == 4'hf) |=>
        retry_limit == $past(st_r.w_data))
        else $error("retry limit not written");
    fine_load_a: assert property (@(posedge clock) disable iff (rst)
        (wr_fire && st_r.aw_addr == bpot_pkg::OFS_DISCARD && st_r.w_strb == 4'hf) |=>
        ({st_r.pri_init, st_r.sec_init} == $past(st_r.w_data)))
        else $error("discard start values not written");
    sel_load_a: assert property (@(posedge clock) disable iff (rst)
        (wr_fire && st_r.aw_addr == bpot_pkg::OFS_TMR_SEL && st_r.w_strb[3]) |=>
        (st_r.sec_init == ($past(st_r.w_data[25]) ? 16'h8000 : 16'h0400) &&
         st_r.pri_init == ($past(st_r.w_data[24]) ? 16'h8000 : 16'h0400)))
        else $error("discard select not applied");
    chassis_wr_a: assert property (@(posedge clock) disable iff (rst)
        (wr_fire && st_r.aw_addr == bpot_pkg::OFS_SLOT_CAP && st_r.w_strb[3]) |=>
        (slot_word[31:24] == $past(st_r.w_data[31:24])))
        else $error("chassis number not written");
endmodule : bpot_regs

/* core/bpot_pkg.sv */
/*
 * bpot_pkg: register map, field positions, reset values and timing counts
 * for the bridge port option and timer block.
 * assumes: 32-bit axi4-lite register access, one 125 MHz clock.
 */
package bpot_pkg;
    localparam logic [7:0]  OFS_PORT_OPT     = 8'h74;
    localparam logic [7:0]  OFS_RETRY        = 8'h78;
    localparam logic [7:0]  OFS_DISCARD      = 8'h80;
    localparam logic [7:0]  OFS_SLOT_CAP     = 8'hb0;
    localparam logic [7:0]  OFS_POWER_CAP    = 8'hdc;
    localparam logic [7:0]  OFS_TMR_SEL      = 8'h3c;
    localparam logic [7:0]  OFS_IRQ_STATUS   = 8'hf0;
    localparam logic [7:0]  OFS_IRQ_MASK     = 8'hf4;
    localparam logic [7:0]  OFS_TMR_STATUS   = 8'hf8;

    localparam int          BIT_SEC_MWI      = 8;
    localparam int          BIT_LONG_LOCK    = 9;
    localparam int          BIT_SEC_HOLD     = 10;
    localparam int          BIT_PRI_HOLD     = 11;
    localparam int          BIT_SEL_PRI      = 24;
    localparam int          BIT_SEL_SEC      = 25;

    localparam logic [3:0]  PORT_OPT_RST     = 4'hc;
    localparam logic [31:0] RETRY_RST        = 32'h0100_0000;
    localparam logic [15:0] DISCARD_RST      = 16'h8000;
    localparam logic [15:0] DISCARD_SHORT    = 16'h0400;
    localparam logic [15:0] DISCARD_LONG     = 16'h8000;
    localparam logic [7:0]  SLOT_CAP_ID      = 8'h04;
    localparam logic [7:0]  SLOT_NEXT_HS     = 8'he4;
    localparam logic [7:0]  SLOT_NEXT_NONE   = 8'h00;
    localparam logic [7:0]  POWER_CAP_ID     = 8'h01;
    localparam logic [7:0]  POWER_NEXT       = 8'hb0;

    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_SLVERR      = 2'b10;
endpackage : bpot_pkg

/* sim/bpot_far_model.sv */
/*
 * bpot_far_model: the bridge datapath beside the option and timer block.
 * It hands over completions, drives the hot swap pin and times each discard.
 * assumes: one clock shared with the block; inputs change just after a rising edge.
 */
`timescale 1ns/1ns
module bpot_far_model (
    input  wire logic clock,
    input  wire logic sec_discard,
    input  wire logic pri_discard,
    output logic      sec_cpl_delivered,
    output logic      pri_cpl_delivered,
    output logic      sec_cpl_retired,
    output logic      pri_cpl_retired,
    output logic      hot_swap_enable_input
);
    int sec_age = 0;
    int pri_age = 0;
    int sec_lat = 0;
    int pri_lat = 0;
    int sec_n   = 0;
    int pri_n   = 0;

    // retire only on request: otherwise every started timer must expire
    initial begin
        sec_cpl_delivered = 1'b0;
        pri_cpl_delivered = 1'b0;
        sec_cpl_retired = 1'b0;
        pri_cpl_retired = 1'b0;
        hot_swap_enable_input = 1'b0;
    end

    task automatic deliver(input bit pri);
        @(posedge clock);
        if (pri) pri_cpl_delivered <= 1'b1;
        else sec_cpl_delivered <= 1'b1;
        @(posedge clock);
        pri_cpl_delivered <= 1'b0;
        sec_cpl_delivered <= 1'b0;
    endtask : deliver

    task automatic retire(input bit pri);
        @(posedge clock);
        if (pri) pri_cpl_retired <= 1'b1;
        else sec_cpl_retired <= 1'b1;
        @(posedge clock);
        pri_cpl_retired <= 1'b0;
        sec_cpl_retired <= 1'b0;
    endtask : retire

    task automatic set_hs(input bit v);
        @(posedge clock);
        hot_swap_enable_input <= v;
    endtask : set_hs

    // age counts edges since the delivery edge; latency is taken at the discard edge
    always @(posedge clock) begin
        sec_age <= sec_cpl_delivered ? 1 : sec_age + 1;
        pri_age <= pri_cpl_delivered ? 1 : pri_age + 1;
        if (sec_discard) begin
            sec_lat <= sec_age;
            sec_n <= sec_n + 1;
        end
        if (pri_discard) begin
            pri_lat <= pri_age;
            pri_n <= pri_n + 1;
        end
    end
endmodule : bpot_far_model

/* sim/tb_top.sv */
/*
 * tb_top: self-checking bench for the option and timer register block.
 * assumes: axi4-lite tasks as the only register path, far side from bpot_far_model.
 */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_top;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq, hs;
    logic        mwi, llock, shold, phold, sdel, pdel, sret, pret, sdis, pdis;
    logic [1:0]  bresp, rresp, last_b, last_r;
    logic [31:0] rdata, last_d, retry;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cycles = 0;

    always #4 clock = ~clock;

    bpot_regs u_bpot_regs (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .hot_swap_enable_input(hs), .sec_cpl_delivered(sdel),
        .pri_cpl_delivered(pdel), .sec_cpl_retired(sret), .pri_cpl_retired(pret),
        .sec_mwi_disconnect(mwi), .long_lock_request(llock), .sec_req_hold(shold),
        .pri_req_hold(phold), .retry_limit(retry), .sec_discard(sdis),
        .pri_discard(pdis), .irq(irq));

    bpot_far_model u_far (.clock(clock), .sec_discard(sdis), .pri_discard(pdis),
        .sec_cpl_delivered(sdel), .pri_cpl_delivered(pdel), .sec_cpl_retired(sret),
        .pri_cpl_retired(pret), .hot_swap_enable_input(hs));

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    // hang guard: the longest countdown is 1024 cycles, the rest is short
    always @(posedge clock) begin
        cycles++;
        if (cycles == 8000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        bit aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clock);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clock);
            if (aw_ok && w_ok && bvalid) break;
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        last_b = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clock);
            if (rvalid) break;
            if (arvalid && arready) arvalid <= 1'b0;
        end
        last_d = rdata;
        last_r = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        `CHK("read data", e, last_d & m)
    endtask : chk_rd

    // start one countdown and judge the edge count from delivery to discard
    task automatic discard_run(input bit pri, input int init);
        int n0;
        int k;
        int lat;
        n0 = pri ? u_far.pri_n : u_far.sec_n;
        u_far.deliver(pri);
        k = 0;
        while ((pri ? u_far.pri_n : u_far.sec_n) == n0 && k < init + 20) begin
            @(posedge clock);
            k++;
        end
        lat = pri ? u_far.pri_lat : u_far.sec_lat;
        `CHK("discard", 1'b1, lat inside {[init-1:init+3]})
        `CHK("discard count", n0 + 1, pri ? u_far.pri_n : u_far.sec_n)
    endtask : discard_run

    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        `CHK("option pins", 4'hc, {phold, shold, llock, mwi})
        chk_rd(bpot_pkg::OFS_PORT_OPT, 32'h0000_0f00, 32'h0000_0c00);
        chk_rd(bpot_pkg::OFS_RETRY, 32'hffff_ffff, 32'h0100_0000);
        chk_rd(bpot_pkg::OFS_DISCARD, 32'hffff_ffff, 32'h8000_8000);
        chk_rd(bpot_pkg::OFS_SLOT_CAP, 32'hffff_ffff, 32'h0000_0004);
        chk_rd(bpot_pkg::OFS_POWER_CAP, 32'h0000_ffff, 32'h0000_b001);
        `CHK("irq", 1'b0, irq)
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            wr(bpot_pkg::OFS_PORT_OPT, 32'h0000_0100 << i, 4'hf);
            `CHK("option pins", 4'(1 << i), {phold, shold, llock, mwi})
            chk_rd(bpot_pkg::OFS_PORT_OPT, 32'h0000_0f00, 32'h0000_0100 << i);
        end
        $display("test options done");
        wr(bpot_pkg::OFS_RETRY, 32'hffff_ffff, 4'hf);
        wr(bpot_pkg::OFS_RETRY, 32'h1234_5678, 4'h1);
        chk_rd(bpot_pkg::OFS_RETRY, 32'hffff_ffff, 32'hffff_ff78);
        `CHK("retry pins", 32'hffff_ff78, retry)
        wr(bpot_pkg::OFS_SLOT_CAP, 32'hffff_ffff, 4'hf);
        chk_rd(bpot_pkg::OFS_SLOT_CAP, 32'hffff_ffff, 32'hff3f_0004);
        u_far.set_hs(1'b1);
        repeat (6) @(posedge clock);
        chk_rd(bpot_pkg::OFS_SLOT_CAP, 32'hffff_ffff, 32'hff3f_e404);
        wr(bpot_pkg::OFS_POWER_CAP, 32'hffff_ffff, 4'hf);
        chk_rd(bpot_pkg::OFS_POWER_CAP, 32'h0000_ffff, 32'h0000_b001);
        $display("test retry and capabilities done");
        wr(bpot_pkg::OFS_IRQ_MASK, 32'h0000_0001, 4'hf);
        wr(bpot_pkg::OFS_DISCARD, 32'h0020_0010, 4'hf);
        chk_rd(bpot_pkg::OFS_DISCARD, 32'hffff_ffff, 32'h0020_0010);
        discard_run(1'b0, 16);
        `CHK("irq", 1'b1, irq)
        discard_run(1'b1, 32);
        chk_rd(bpot_pkg::OFS_IRQ_STATUS, 32'h0000_0003, 32'h0000_0003);
        wr(bpot_pkg::OFS_IRQ_STATUS, 32'h0000_0001, 4'hf);
        `CHK("irq", 1'b0, irq)
        chk_rd(bpot_pkg::OFS_IRQ_STATUS, 32'h0000_0003, 32'h0000_0002);
        wr(bpot_pkg::OFS_IRQ_STATUS, 32'h0000_0002, 4'hf);
        chk_rd(bpot_pkg::OFS_IRQ_STATUS, 32'h0000_0003, 32'h0000_0000);
        // select byte last: sec takes the long step, pri the short one
        wr(bpot_pkg::OFS_TMR_SEL, 32'h0200_0000, 4'h8);
        chk_rd(bpot_pkg::OFS_DISCARD, 32'hffff_ffff, 32'h0400_8000);
        discard_run(1'b1, 1024);
        wr(bpot_pkg::OFS_DISCARD, 32'h0005_0006, 4'hf);
        chk_rd(bpot_pkg::OFS_DISCARD, 32'hffff_ffff, 32'h0005_0006);
        discard_run(1'b0, 6);
        u_far.deliver(1'b0);
        u_far.retire(1'b0);
        repeat (20) @(posedge clock);
        `CHK("discard count", 2, u_far.sec_n)
        chk_rd(bpot_pkg::OFS_TMR_STATUS, 32'h0003_0000, 32'h0000_0000);
        $display("test discard timers done");
        rd(8'h40);
        `CHK("read resp", bpot_pkg::RESP_SLVERR, last_r)
        `CHK("read data", 32'h0, last_d)
        wr(8'h40, 32'hffff_ffff, 4'hf);
        `CHK("write resp", bpot_pkg::RESP_OKAY, last_b)
        $display("test unmapped done");
        end_sim();
    end
endmodule : tb_top
